// ==== dv/tio_ext_instr.sv ====
// Model of the external instrument wired to the trigger pin.
`timescale 1ns/100ps
module tio_ext_instr (
	// Clock.
	input wire logic i_clk,
	// Pin drive.
	output logic o_en,
	output logic o_lvl
);
	// Released at start, so the pull-up holds the pin high.
	initial begin
		o_en = 1'b0;
		o_lvl = 1'b0;
	end
	// Drive a steady level, or release the pin when en is low.
	task automatic hold(input logic en, input logic lvl);
		@(posedge i_clk);
		o_en <= en;
		o_lvl <= lvl;
	endtask
	// Low pulse held for n cycles, then released.
	task automatic pulse(input int n);
		hold(1'b1, 1'b0);
		repeat (n) @(posedge i_clk);
		o_en <= 1'b0;
	endtask
endmodule

// ==== dv/tio_trigger_pin_asserts.sv ====
// Checker of the trigger I/O pin port behaviour.
`timescale 1ns/100ps
module tio_trigger_pin_asserts
	import tio_pkg::*;
#(
	parameter int LOW_CYCLES = TIO_LOW_CYCLES
) (
	// Clock, reset and register writes.
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_write,
	// Trigger, pin and starts.
	input wire logic i_internal_trig,
	input wire logic i_pin,
	input wire logic o_pin,
	input wire logic o_pin_oe,
	input wire logic o_start_meter,
	input wire logic o_start_dlog,
	input wire logic o_start_sequence,
	input wire logic o_input_value
);
	logic [8:0] ctrl;
	logic [3:0] age, pst;
	logic [TIO_CNT_W-1:0] olow, plow;
	logic armed, pin_q;
	wire cmd_w = i_write && i_addr == TIO_OFS_COMMAND;
	wire loc_w = cmd_w && i_wdata[0];
	wire tout = ctrl[1:0] == 2'b00 && ctrl[2];
	wire tin = ctrl[1:0] == 2'b00 && !ctrl[2];
	wire olvl = o_pin ^ ctrl[5];
	// Shadow of the control word, its age, the meter arm and low-time counters.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl <= TIO_CTRL_RESET;
			age <= 4'h0;
			pst <= 4'h0;
			olow <= 12'h000;
			plow <= 12'h000;
			armed <= 1'b0;
			pin_q <= 1'b1;
		end else begin
			if (i_write && i_addr == TIO_OFS_CTRL) begin
				ctrl <= i_wdata[8:0];
				age <= 4'h0;
			end else begin
				age <= age + {3'h0, age != 4'hf};
			end
			pin_q <= i_pin;
			pst <= (i_pin != pin_q) ? 4'h0 : pst + {3'h0, pst != 4'hf};
			olow <= olvl ? 12'h000 : olow + {11'h000, olow != 12'hfff};
			plow <= i_pin ? 12'h000 : plow + {11'h000, plow != 12'hfff};
			armed <= (cmd_w && i_wdata[1]) || (armed && !o_start_meter);
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	property p_oe_mode;
		o_pin_oe && age > 4'h1 |-> tout || ctrl[1:0] == 2'b10;
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("pin driven in a non-drive mode");
	property p_tout_start;
		tout && age > 4'h2 && i_internal_trig && olvl |=> !olvl;
	endproperty
	a_tout_start: assert property (p_tout_start) else $error("no pulse after trigger");
	property p_tout_len;
		tout && age > 4'h2 && $rose(olvl) |-> olow >= LOW_CYCLES;
	endproperty
	a_tout_len: assert property (p_tout_len) else $error("trigger pulse too short");
	property p_out_level;
		ctrl[1:0] == 2'b10 && !ctrl[7] && age > 4'h2 |-> o_pin_oe && o_pin == (ctrl[5] ^ !ctrl[6]);
	endproperty
	a_out_level: assert property (p_out_level) else $error("wrong output level");
	property p_in_level;
		ctrl[1:0] == 2'b01 && age > 4'h8 && pst > 4'h8 |-> o_input_value == (i_pin ^ ctrl[5]);
	endproperty
	a_in_level: assert property (p_in_level) else $error("wrong input value");
	property p_tin_start;
		tin && ctrl[5:3] == 3'b001 && age > 4'h4 && $rose(i_pin) && $past(plow) >= LOW_CYCLES + 2
			|-> ##[1:8] o_start_dlog;
	endproperty
	a_tin_start: assert property (p_tin_start) else $error("pin pulse started nothing");
	property p_meter_arm;
		o_start_meter |-> armed && tin && ctrl[4:3] == 2'b00;
	endproperty
	a_meter_arm: assert property (p_meter_arm) else $error("meter start unarmed");
	property p_seq_src;
		$rose(o_start_sequence) && !ctrl[8] |-> $past(loc_w) || $past(loc_w, 2);
	endproperty
	a_seq_src: assert property (p_seq_src) else $error("sequence start from pin");
	property p_local_seq;
		loc_w && !ctrl[8] |-> ##[1:2] o_start_sequence;
	endproperty
	a_local_seq: assert property (p_local_seq) else $error("local trigger lost");
endmodule
bind tio_trigger_pin tio_trigger_pin_asserts #(.LOW_CYCLES(LOW_CYCLES)) i_chk (
	.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_write(i_write), .i_internal_trig(i_internal_trig), .i_pin(i_pin), .o_pin(o_pin),
	.o_pin_oe(o_pin_oe), .o_start_meter(o_start_meter), .o_start_dlog(o_start_dlog),
	.o_start_sequence(o_start_sequence), .o_input_value(o_input_value));

// ==== dv/tio_trigger_pin_bench.sv ====
// Self-checking bench of the trigger I/O pin block.
`timescale 1ns/100ps
module tio_trigger_pin_bench;
	import tio_pkg::*;
	localparam int LC = 4;
	logic clk, rst, wr, rd, itrig;
	logic [3:0] addr;
	logic [15:0] wdata, got;
	logic [2:0] seen;
	wire logic [15:0] rdata;
	wire logic pin_o, oe, sm, sd, ss, ival, ext_en, ext_lvl;
	// Pin level: the block, else the instrument, else the pull-up.
	wire logic pin = oe ? pin_o : (ext_en ? ext_lvl : 1'b1);
	int n_fail = 0;
	int samples_checked = 0;
	int lows;
	// Rows: control word, instrument releases, expected pin, enable, input value.
	localparam logic [12:0] ROWS [9] = '{{9'h000, 4'b1000}, {9'h001, 4'b0100},
		{9'h001, 4'b1101}, {9'h021, 4'b1100}, {9'h021, 4'b0101}, {9'h002, 4'b1111},
		{9'h042, 4'b1011}, {9'h062, 4'b1111}, {9'h022, 4'b1011}};
	// Trigger-in cases: control word, arm first, expected starts {sequence, dlog, meter}.
	localparam logic [12:0] TIN [5] = '{{9'h000, 4'b1001}, {9'h008, 4'b0010},
		{9'h110, 4'b0100}, {9'h010, 4'b0000}, {9'h000, 4'b0000}};
	// Design and the instrument on its pin.
	tio_trigger_pin #(.LOW_CYCLES(LC)) i_tio_trigger_pin (.i_core_clk(clk), .i_reset(rst),
		.i_addr(addr), .i_wdata(wdata), .i_write(wr), .i_read(rd), .o_rdata(rdata),
		.i_internal_trig(itrig), .i_pin(pin), .o_pin(pin_o), .o_pin_oe(oe),
		.o_start_meter(sm), .o_start_dlog(sd), .o_start_sequence(ss), .o_input_value(ival));
	tio_ext_instr i_tio_ext_instr (.i_clk(clk), .o_en(ext_en), .o_lvl(ext_lvl));
	// Compare and count.
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Register bus cycles.
	task automatic wrt(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask
	// Gather start pulses and low pin cycles over n cycles.
	task automatic watch(input int n);
		seen = 3'b000;
		lows = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			seen = seen | {ss, sd, sm};
			if (!pin_o) lows++;
		end
	endtask
	// Reset values and an unmapped place.
	task automatic check_reset;
		#1;
		chk(oe, 1'b0);
		chk(pin_o, 1'b1);
		rdr(TIO_OFS_CTRL);
		chk(got, 16'h0000);
		rdr(TIO_OFS_PWM_PERIOD);
		chk(got, TIO_PWM_PERIOD_RESET);
		rdr(TIO_OFS_PWM_HIGH);
		chk(got, TIO_PWM_HIGH_RESET);
		wrt(4'hf, 16'hffff);
		rdr(4'hf);
		chk(got, 16'h0000);
		$display("test reset finished");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog.
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		stop_test();
	end
	// Main sequence.
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		itrig = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check_reset();
		for (int i = 0; i < 9; i++) begin
			wrt(TIO_OFS_CTRL, {7'h00, ROWS[i][12:4]});
			i_tio_ext_instr.hold(!ROWS[i][3], 1'b0);
			repeat (16) @(posedge clk);
			#1;
			if (ROWS[i][1]) chk(pin_o, ROWS[i][2]);
			chk(oe, ROWS[i][1]);
			chk(ival, ROWS[i][0]);
			rdr(TIO_OFS_CTRL);
			chk(got, {7'h00, ROWS[i][12:4]});
		end
		rdr(TIO_OFS_STATUS);
		chk(got, 16'h0001);
		$display("test rows finished");
		// Trigger out from the internal event, then from a local command.
		wrt(TIO_OFS_CTRL, 16'h0004);
		fork
			begin
				repeat (4) @(posedge clk);
				itrig <= 1'b1;
				@(posedge clk);
				itrig <= 1'b0;
			end
			watch(LC + 12);
		join
		chk(lows >= LC && lows <= LC + 1, 1'b1);
		fork
			wrt(TIO_OFS_COMMAND, 16'h0001);
			watch(LC + 12);
		join
		chk(seen[2], 1'b1);
		chk(lows >= LC, 1'b1);
		$display("test trigger out finished");
		// Pin pulses into each target and source.
		for (int i = 0; i < 5; i++) begin
			wrt(TIO_OFS_CTRL, {7'h00, TIN[i][12:4]});
			if (TIN[i][3]) wrt(TIO_OFS_COMMAND, 16'h0002);
			fork
				i_tio_ext_instr.pulse(LC + 3);
				watch(LC + 20);
			join
			chk(seen, TIN[i][2:0]);
		end
		$display("test trigger in finished");
		// PWM output, then a reset in mid-run.
		wrt(TIO_OFS_PWM_PERIOD, 16'h0004);
		wrt(TIO_OFS_PWM_HIGH, 16'h0002);
		wrt(TIO_OFS_CTRL, 16'h0082);
		watch(16);
		chk(lows >= 6 && lows <= 10, 1'b1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		check_reset();
		stop_test();
	end
endmodule

// ==== rtl/tio_pkg.sv ====
// Package of constants and types for the trigger I/O pin block.
package tio_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] TIO_OFS_CTRL = 4'h0;
	localparam logic [3:0] TIO_OFS_PWM_PERIOD = 4'h1;
	localparam logic [3:0] TIO_OFS_PWM_HIGH = 4'h2;
	localparam logic [3:0] TIO_OFS_STATUS = 4'h3;
	localparam logic [3:0] TIO_OFS_COMMAND = 4'h4;

	// Control register fields.
	localparam int TIO_CTRL_FUNC_LSB = 0;
	localparam int TIO_CTRL_DIR_BIT = 2;
	localparam int TIO_CTRL_TARGET_LSB = 3;
	localparam int TIO_CTRL_INVERT_BIT = 5;
	localparam int TIO_CTRL_OUTSEL_LSB = 6;
	localparam int TIO_CTRL_SEQSRC_BIT = 8;
	localparam logic [8:0] TIO_CTRL_RESET = 9'h000;

	// Command register fields.
	localparam int TIO_CMD_TRIG_BIT = 0;
	localparam int TIO_CMD_ACQ_BIT = 1;

	// Status register fields.
	localparam int TIO_STAT_LEVEL_BIT = 0;
	localparam int TIO_STAT_ARMED_BIT = 1;
	localparam int TIO_STAT_PULSE_BIT = 2;

	// Timing: least low time of a trigger pulse.
	localparam int TIO_CLK_HZ = 25000000;
	localparam int TIO_LOW_MIN_US = 30;
	localparam int TIO_LOW_CYCLES = (TIO_LOW_MIN_US * TIO_CLK_HZ + 999999) / 1000000;
	localparam int TIO_CNT_W = 12;
	localparam logic [TIO_CNT_W-1:0] TIO_LOW_CNT = TIO_CNT_W'(TIO_LOW_CYCLES);
	localparam logic [TIO_CNT_W-1:0] TIO_CNT_ZERO = 12'h000;
	localparam logic [TIO_CNT_W-1:0] TIO_CNT_ONE = 12'h001;

	// PWM defaults.
	localparam int TIO_PWM_W = 16;
	localparam logic [15:0] TIO_PWM_PERIOD_RESET = 16'h0064;
	localparam logic [15:0] TIO_PWM_HIGH_RESET = 16'h0032;

	// Pin functions.
	typedef enum logic [1:0] {
		TIO_FUNC_TRIG = 2'b00,
		TIO_FUNC_INPUT = 2'b01,
		TIO_FUNC_OUTPUT = 2'b10
	} tio_func_t;

	// Trigger-input targets.
	typedef enum logic [1:0] {
		TIO_TGT_METER = 2'b00,
		TIO_TGT_DLOG = 2'b01,
		TIO_TGT_SEQ = 2'b10
	} tio_target_t;

	// Output value selection.
	typedef enum logic [1:0] {
		TIO_OUT_FALSE = 2'b00,
		TIO_OUT_TRUE = 2'b01,
		TIO_OUT_PWM = 2'b10
	} tio_outsel_t;

	// Trigger-output pulse generator states.
	typedef enum logic [0:0] {
		TIO_PST_IDLE = 1'b0,
		TIO_PST_LOW = 1'b1
	} tio_pstate_t;

endpackage

// ==== rtl/tio_pwm.sv ====
// PWM waveform generator for the trigger I/O pin.
`timescale 1ns/100ps
module tio_pwm
	import tio_pkg::*;
#(
	parameter int W = TIO_PWM_W
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Settings.
	input wire logic [W-1:0] i_period,
	input wire logic [W-1:0] i_high,
	// Waveform.
	output logic o_wave
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic wave;
	logic next_wave;

	// Counts one period of i_period cycles; high while count is below i_high.
	always_comb begin
		if (count + W'(1) >= i_period) begin
			next_count = '0;
		end else begin
			next_count = count + W'(1);
		end
		next_wave = (next_count < i_high);
	end

	// Registers the counter and the waveform.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			count <= '0;
			wave <= 1'b0;
		end else begin
			count <= next_count;
			wave <= next_wave;
		end
	end

	assign o_wave = wave;
endmodule

// ==== rtl/tio_trigger_pin.sv ====
// Trigger I/O pin: trigger, level input and digital output functions.
`timescale 1ns/100ps
module tio_trigger_pin
	import tio_pkg::*;
#(
	parameter int LOW_CYCLES = TIO_LOW_CYCLES
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Register port.
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [15:0] o_rdata,
	// Internal trigger event from the instrument.
	input wire logic i_internal_trig,
	// Pin.
	input wire logic i_pin,
	output logic o_pin,
	output logic o_pin_oe,
	// Starts of target functions.
	output logic o_start_meter,
	output logic o_start_dlog,
	output logic o_start_sequence,
	// Level input value.
	output logic o_input_value
);
	localparam logic [TIO_CNT_W-1:0] LOW_CNT = TIO_CNT_W'(LOW_CYCLES);

	// Register state.
	logic [8:0] ctrl;
	logic [8:0] next_ctrl;
	logic [15:0] pwm_period;
	logic [15:0] next_pwm_period;
	logic [15:0] pwm_high;
	logic [15:0] next_pwm_high;
	logic meter_armed;
	logic next_meter_armed;
	logic [15:0] rdata;
	logic [15:0] next_rdata;

	// Pin synchroniser and filter.
	logic sync1;
	logic sync2;
	logic sync3;
	logic pin_level;
	logic next_pin_level;
	logic [TIO_CNT_W-1:0] low_count;
	logic [TIO_CNT_W-1:0] next_low_count;
	logic low_seen;
	logic next_low_seen;

	// Pulse generator.
	tio_pstate_t pstate;
	tio_pstate_t next_pstate;
	logic [TIO_CNT_W-1:0] pcount;
	logic [TIO_CNT_W-1:0] next_pcount;

	// Registered outputs.
	logic pin_out;
	logic next_pin_out;
	logic pin_oe;
	logic next_pin_oe;
	logic start_meter;
	logic next_start_meter;
	logic start_dlog;
	logic next_start_dlog;
	logic start_seq;
	logic next_start_seq;
	logic input_value;
	logic next_input_value;

	// Decoded settings.
	tio_func_t func;
	tio_target_t target;
	tio_outsel_t outsel;
	logic invert;
	logic dir_out;
	logic seq_src_ext;
	logic pwm_wave;
	logic cmd_trig;
	logic cmd_acq;
	logic ext_pulse;
	logic any_trig;

	assign func = tio_func_t'(ctrl[TIO_CTRL_FUNC_LSB +: 2]);
	assign dir_out = ctrl[TIO_CTRL_DIR_BIT];
	assign target = tio_target_t'(ctrl[TIO_CTRL_TARGET_LSB +: 2]);
	assign invert = ctrl[TIO_CTRL_INVERT_BIT];
	assign outsel = tio_outsel_t'(ctrl[TIO_CTRL_OUTSEL_LSB +: 2]);
	assign seq_src_ext = ctrl[TIO_CTRL_SEQSRC_BIT];
	assign cmd_trig = i_write && (i_addr == TIO_OFS_COMMAND) && i_wdata[TIO_CMD_TRIG_BIT];
	assign cmd_acq = i_write && (i_addr == TIO_OFS_COMMAND) && i_wdata[TIO_CMD_ACQ_BIT];

	// PWM source for the output function.
	tio_pwm #(
		.W(TIO_PWM_W)
	) u_pwm (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_period(pwm_period),
		.i_high(pwm_high),
		.o_wave(pwm_wave)
	);

	// Register writes and read data.
	always_comb begin
		next_ctrl = ctrl;
		next_pwm_period = pwm_period;
		next_pwm_high = pwm_high;
		next_rdata = 16'h0000;
		if (i_write) begin
			case (i_addr)
				TIO_OFS_CTRL: next_ctrl = i_wdata[8:0];
				TIO_OFS_PWM_PERIOD: next_pwm_period = i_wdata;
				TIO_OFS_PWM_HIGH: next_pwm_high = i_wdata;
				default: next_ctrl = ctrl;
			endcase
		end
		if (i_read) begin
			case (i_addr)
				TIO_OFS_CTRL: next_rdata = {7'h00, ctrl};
				TIO_OFS_PWM_PERIOD: next_rdata = pwm_period;
				TIO_OFS_PWM_HIGH: next_rdata = pwm_high;
				TIO_OFS_STATUS: begin
					next_rdata[TIO_STAT_LEVEL_BIT] = input_value;
					next_rdata[TIO_STAT_ARMED_BIT] = meter_armed;
					next_rdata[TIO_STAT_PULSE_BIT] = (pstate == TIO_PST_LOW);
				end
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// Filters the pin: a low level that lasts the least low time counts as a pulse once the pin returns high.
	always_comb begin
		next_pin_level = pin_level;
		if (sync2 == sync3) begin
			next_pin_level = sync3;
		end
		// Polarity applies before the pulse is measured.
		next_low_count = low_count;
		next_low_seen = low_seen;
		ext_pulse = 1'b0;
		if (func != TIO_FUNC_TRIG || dir_out) begin
			next_low_seen = 1'b0; // Filter rests outside trigger-in; no stale low replays.
			next_low_count = TIO_CNT_ZERO;
		end else if ((pin_level ^ invert) == 1'b0) begin
			if (low_count != LOW_CNT) begin
				next_low_count = low_count + TIO_CNT_ONE;
			end else begin
				next_low_seen = 1'b1;
			end
		end else begin
			ext_pulse = low_seen;
			next_low_seen = 1'b0;
			next_low_count = TIO_CNT_ZERO;
		end
	end

	// Trigger input dispatch, meter arming and level input value.
	always_comb begin
		next_start_meter = 1'b0;
		next_start_dlog = 1'b0;
		next_start_seq = 1'b0;
		next_meter_armed = meter_armed;
		next_input_value = input_value;
		any_trig = i_internal_trig || (cmd_trig && !seq_src_ext);
		if (cmd_acq) begin
			next_meter_armed = 1'b1;
		end
		if (cmd_trig && !seq_src_ext) begin
			next_start_seq = 1'b1;
		end
		if (func == TIO_FUNC_TRIG && !dir_out && ext_pulse) begin
			case (target)
				TIO_TGT_METER: begin
					next_start_meter = meter_armed || cmd_acq;
					next_meter_armed = 1'b0;
				end
				TIO_TGT_DLOG: next_start_dlog = 1'b1;
				TIO_TGT_SEQ: next_start_seq = seq_src_ext || next_start_seq;
				default: next_start_dlog = 1'b0;
			endcase
		end
		if (func == TIO_FUNC_INPUT) begin
			next_input_value = pin_level ^ invert;
		end
	end

	// Trigger-output pulse generator.
	always_comb begin
		next_pstate = pstate;
		next_pcount = pcount;
		case (pstate)
			TIO_PST_IDLE: begin
				if (func == TIO_FUNC_TRIG && dir_out && any_trig) begin
					next_pstate = TIO_PST_LOW;
					next_pcount = TIO_CNT_ONE;
				end
			end
			TIO_PST_LOW: begin
				if (pcount >= LOW_CNT) begin
					next_pstate = TIO_PST_IDLE;
				end else begin
					next_pcount = pcount + TIO_CNT_ONE;
				end
			end
			default: next_pstate = TIO_PST_IDLE;
		endcase
	end

	// Pin drive by function and polarity.
	always_comb begin
		next_pin_out = 1'b1;
		next_pin_oe = 1'b0;
		case (func)
			TIO_FUNC_TRIG: begin
				next_pin_oe = dir_out;
				next_pin_out = (next_pstate != TIO_PST_LOW) ^ invert;
			end
			TIO_FUNC_OUTPUT: begin
				next_pin_oe = 1'b1;
				case (outsel)
					TIO_OUT_TRUE: next_pin_out = invert;
					TIO_OUT_FALSE: next_pin_out = !invert;
					TIO_OUT_PWM: next_pin_out = pwm_wave ^ invert;
					default: next_pin_out = !invert;
				endcase
			end
			default: next_pin_oe = 1'b0;
		endcase
	end

	// Registers all state.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl <= TIO_CTRL_RESET;
			pwm_period <= TIO_PWM_PERIOD_RESET;
			pwm_high <= TIO_PWM_HIGH_RESET;
			meter_armed <= 1'b0;
			rdata <= 16'h0000;
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
			pin_level <= 1'b1;
			low_count <= TIO_CNT_ZERO;
			low_seen <= 1'b0;
			pstate <= TIO_PST_IDLE;
			pcount <= TIO_CNT_ZERO;
			pin_out <= 1'b1;
			pin_oe <= 1'b0;
			start_meter <= 1'b0;
			start_dlog <= 1'b0;
			start_seq <= 1'b0;
			input_value <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			pwm_period <= next_pwm_period;
			pwm_high <= next_pwm_high;
			meter_armed <= next_meter_armed;
			rdata <= next_rdata;
			sync1 <= i_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_level <= next_pin_level;
			low_count <= next_low_count;
			low_seen <= next_low_seen;
			pstate <= next_pstate;
			pcount <= next_pcount;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			start_meter <= next_start_meter;
			start_dlog <= next_start_dlog;
			start_seq <= next_start_seq;
			input_value <= next_input_value;
		end
	end

	assign o_rdata = rdata;
	assign o_pin = pin_out;
	assign o_pin_oe = pin_oe;
	assign o_start_meter = start_meter;
	assign o_start_dlog = start_dlog;
	assign o_start_sequence = start_seq;
	assign o_input_value = input_value;
endmodule
